/* File: common/pbcb_pkg.sv */
`default_nettype none
package pbcb_pkg;

   // ************************************************************
   // register indices (byte address is four times the index)
   // ************************************************************
   localparam logic [5:0] IDX_BATT_CTRL = 6'h05;
   localparam logic [5:0] IDX_BATT_STAT = 6'h06;
   localparam logic [5:0] IDX_CODING    = 6'h1C;
   localparam logic [5:0] IDX_STATION   = 6'h1D;
   localparam logic [5:0] IDX_FRAMING   = 6'h1E;
   localparam logic [5:0] IDX_BANK      = 6'h1F;
   localparam int         NREG          = 6;

   // slot numbers of the write-select vector
   localparam int SLOT_BATT_CTRL = 0;
   localparam int SLOT_BATT_STAT = 1;
   localparam int SLOT_CODING    = 2;
   localparam int SLOT_STATION   = 3;
   localparam int SLOT_FRAMING   = 4;
   localparam int SLOT_BANK      = 5;
   localparam logic [5:0] SLOT_IDX [NREG] = '{IDX_BATT_CTRL, IDX_BATT_STAT, IDX_CODING,
                                              IDX_STATION, IDX_FRAMING, IDX_BANK};

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] RST_BATT_CTRL = 8'hB1;
   localparam logic [7:0] RST_BATT_STAT = 8'h96;
   localparam logic [7:0] RST_CODING    = 8'h00;
   localparam logic [7:0] RST_STATION   = 8'h00;
   localparam logic [7:0] RST_FRAMING   = 8'h00;
   localparam logic [7:0] RST_BANK      = 8'h00;

   // ************************************************************
   // field positions and write masks
   // ************************************************************
   localparam int BIT_LINE_CODE   = 7;
   localparam int LEN_MSB         = 6;
   localparam int BIT_FRAME_MODE  = 7;
   localparam int PRE_MSB         = 6;
   localparam int PRE_LSB         = 5;
   localparam int BIT_WHITEN      = 4;
   localparam int BIT_CHECKSUM    = 3;
   localparam int MATCH_MSB       = 2;
   localparam int MATCH_LSB       = 1;
   localparam int BIT_CHK_STAT    = 0;
   localparam int BIT_AUTO_FLUSH  = 7;
   localparam int BIT_BUF_DIR     = 6;
   localparam int BANK_MSB        = 1;
   localparam int BIT_MON_EN      = 3;
   localparam int THR_MSB         = 2;
   localparam int BIT_SUP_STAT    = 7;
   localparam int BIT_ALERT_ROUTE = 6;
   localparam logic [7:0] MASK_BANK     = 8'hC3;
   localparam logic [7:0] MASK_FRAMING  = 8'hFE;
   localparam logic [7:0] MASK_BATT_STAT = 8'h7F;

   // ************************************************************
   // enumerations and constants
   // ************************************************************
   typedef enum logic [1:0] {
      PAGE_0 = 2'b00,
      PAGE_1 = 2'b01,
      PAGE_2 = 2'b10,
      PAGE_3 = 2'b11
   } pbcb_page_type;

   typedef enum logic [1:0] {
      MATCH_NONE  = 2'b00,
      MATCH_NODE  = 2'b01,
      MATCH_ZERO  = 2'b10,
      MATCH_BOTH  = 2'b11
   } pbcb_match_type;

   localparam logic [7:0] BCAST_ZERO = 8'h00;
   localparam logic [7:0] BCAST_ONES = 8'hFF;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic       HRESP_OKAY    = 1'b0;

endpackage
`default_nettype wire

/* File: common/pbcb_rx_if.sv */
`timescale 1ns/1ps
`default_nettype none
// settings and events between the register bank and the receive checker
interface pbcb_rx_if;
   import pbcb_pkg::*;
   logic [7:0]     station_id;
   pbcb_match_type match_mode;
   logic           checksum_en;
   logic           auto_flush;
   logic           status_clr;
   logic           rx_active;
   logic           crc_done;
   logic           crc_ok;
   logic           addr_valid;
   logic [7:0]     addr_byte;
   logic           crc_status;
   logic           addr_accept_valid;
   logic           addr_accept;
   logic           flush;

   modport bank (
      output station_id, match_mode, checksum_en, auto_flush, status_clr,
             rx_active, crc_done, crc_ok, addr_valid, addr_byte,
      input  crc_status, addr_accept_valid, addr_accept, flush
   );
   modport check (
      input  station_id, match_mode, checksum_en, auto_flush, status_clr,
             rx_active, crc_done, crc_ok, addr_valid, addr_byte,
      output crc_status, addr_accept_valid, addr_accept, flush
   );
endinterface
`default_nettype wire

/* File: hdl/pbcb_rx_check.sv */
`timescale 1ns/1ps
`default_nettype none
module pbcb_rx_check (
   input  wire logic hclk,        // system clock
   input  wire logic hresetn,     // async reset, active low
   pbcb_rx_if.check  rx           // settings in, results out
);
   import pbcb_pkg::*;

   logic hit_node;
   logic hit_zero;
   logic hit_ones;
   logic accept;

   // ************************************************************
   // checksum result flag
   // ************************************************************
   // a result arriving with a clear wins, so no outcome is lost
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx.crc_status <= 1'b0;
      end else if (rx.crc_done && rx.checksum_en) begin
         rx.crc_status <= rx.crc_ok;
      end else if (rx.status_clr) begin
         rx.crc_status <= 1'b0;
      end
   end

   // flush pulse only on a failed check while receiving
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx.flush <= 1'b0;
      end else begin
         rx.flush <= rx.crc_done && rx.checksum_en && !rx.crc_ok
                     && rx.rx_active && !rx.auto_flush;
      end
   end

   // ************************************************************
   // address filter
   // ************************************************************
   assign hit_node = (rx.addr_byte == rx.station_id);
   assign hit_zero = (rx.addr_byte == BCAST_ZERO);
   assign hit_ones = (rx.addr_byte == BCAST_ONES);

   always_comb begin
      unique case (rx.match_mode)
         MATCH_NONE: accept = 1'b1;
         MATCH_NODE: accept = hit_node;
         MATCH_ZERO: accept = hit_node || hit_zero;
         MATCH_BOTH: accept = hit_node || hit_zero || hit_ones;
      endcase
   end

   // verdict registered one cycle after the address byte
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx.addr_accept_valid <= 1'b0;
         rx.addr_accept       <= 1'b0;
      end else begin
         rx.addr_accept_valid <= rx.addr_valid;
         rx.addr_accept       <= rx.addr_valid && accept;
      end
   end

endmodule // pbcb_rx_check
`default_nettype wire

/* File: hdl/pbcb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pbcb_top (
   input  wire logic                 hclk,              // bus clock, 250 MHz
   input  wire logic                 hresetn,           // async reset, active low
   input  wire logic                 hsel,              // slave select
   input  wire logic [31:0]          haddr,             // byte address
   input  wire logic [1:0]           htrans,            // transfer type
   input  wire logic                 hwrite,            // 1 = write
   input  wire logic [2:0]           hsize,             // transfer size
   input  wire logic [31:0]          hwdata,            // write data
   input  wire logic                 hready,            // bus ready in
   output logic                      hreadyout,         // never stalls
   output logic                      hresp,             // always okay
   output logic [31:0]               hrdata,            // read data, registered
   output logic                      line_coding_en,    // manchester on
   output logic [6:0]                pkt_len,           // length field
   output logic                      frame_variable,    // 1 = variable length
   output logic [2:0]                preamble_bytes,    // 1 to 4
   output logic                      whitening_en,      // scrambler on
   output logic                      checksum_en,       // crc on
   output pbcb_pkg::pbcb_match_type  addr_match_mode,   // filter mode
   output logic [7:0]                station_id,        // node value
   input  wire logic                 standby,           // device in standby
   output logic                      fifo_read_select,  // host reaches read fifo
   input  wire logic                 rx_active,         // receive operation
   input  wire logic                 crc_done,          // check finished, pulse
   input  wire logic                 crc_ok,            // check passed
   output logic                      fifo_flush,        // clear fifo, pulse
   input  wire logic                 rx_addr_valid,     // address byte strobe
   input  wire logic [7:0]           rx_addr_byte,      // received address
   output logic                      rx_addr_done,      // verdict strobe
   output logic                      rx_addr_accept,    // packet accepted
   output logic                      supply_monitor_enable, // detector on
   output logic [2:0]                supply_threshold,  // trip level code
   input  wire logic                 supply_above,      // comparator level
   output logic                      low_supply_pin     // alert output pin
);
   import pbcb_pkg::*;

   // ************************************************************
   // storage
   // ************************************************************
   logic [7:0]    coding_r;
   logic [7:0]    station_r;
   logic [7:0]    framing_r;
   logic [7:0]    bank_r;
   logic [7:0]    batt_ctrl_r;
   logic [7:0]    batt_stat_r;
   logic [NREG-1:0] wsel_r;
   logic [NREG-1:0] wsel_nxt;
   logic [NREG-1:0] vis;
   logic [7:0]    rd_byte;
   logic [7:0]    wbyte;
   logic [5:0]    ap_idx;
   logic          ap_valid;
   logic          ap_mapped;
   logic          crc_status;
   pbcb_page_type page;

   pbcb_rx_if rx_bus ();

   // ************************************************************
   // address phase decode
   // ************************************************************
   assign ap_valid  = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign ap_idx    = haddr[7:2];
   // only aligned words in the low 256 bytes can hit a register
   assign ap_mapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
   assign page      = pbcb_page_type'(bank_r[BANK_MSB:0]);
   assign wbyte     = hwdata[7:0];

   // which registers the current page shows
   generate
      for (genvar g = 0; g < NREG; g++) begin : g_vis
         always_comb begin
            if (SLOT_IDX[g] == IDX_BANK) begin
               vis[g] = 1'b1;
            end else if (SLOT_IDX[g] == IDX_BATT_CTRL || SLOT_IDX[g] == IDX_BATT_STAT) begin
               vis[g] = (page == PAGE_1);
            end else begin
               vis[g] = (page == PAGE_0);
            end
         end
         // pages 2 and 3 show only the bank register
         assign wsel_nxt[g] = ap_valid && hwrite && ap_mapped
                              && (ap_idx == SLOT_IDX[g]) && vis[g];
      end
   endgenerate

   // write strobes carried into the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wsel_r <= '0;
      end else begin
         wsel_r <= wsel_nxt;
      end
   end

   // ************************************************************
   // read path
   // ************************************************************
   // unused bank bits read as zero, battery reserved bits read as stored; hidden pages read zero
   always_comb begin
      rd_byte = 8'h00;
      if (ap_mapped) begin
         unique case (ap_idx)
            IDX_CODING:    if (vis[SLOT_CODING])    rd_byte = coding_r;
            IDX_STATION:   if (vis[SLOT_STATION])   rd_byte = station_r;
            IDX_FRAMING:   if (vis[SLOT_FRAMING])
                              rd_byte = {framing_r[7:1], crc_status};
            IDX_BANK:      rd_byte = bank_r & MASK_BANK;
            IDX_BATT_CTRL: if (vis[SLOT_BATT_CTRL]) rd_byte = batt_ctrl_r;
            IDX_BATT_STAT: if (vis[SLOT_BATT_STAT])
                              rd_byte = {supply_above, batt_stat_r[6:0]};
            default:       rd_byte = 8'h00;
         endcase
      end
   end

   // data captured at the address edge so hrdata is a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (ap_valid && !hwrite) begin
         hrdata <= {24'h000000, rd_byte};
      end
   end

   // zero wait states, so the slave is always ready
   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;

   // ************************************************************
   // packet handler settings
   // ************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         coding_r <= RST_CODING;
      end else if (wsel_r[SLOT_CODING]) begin
         coding_r <= wbyte;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         station_r <= RST_STATION;
      end else if (wsel_r[SLOT_STATION]) begin
         station_r <= wbyte;
      end
   end

   // bit 0 is the checksum flag, kept in the checker module
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         framing_r <= RST_FRAMING;
      end else if (wsel_r[SLOT_FRAMING]) begin
         framing_r <= wbyte & MASK_FRAMING;
      end
   end

   // a 1 written to the flag position clears it
   assign rx_bus.status_clr = wsel_r[SLOT_FRAMING] && wbyte[BIT_CHK_STAT];

   // ************************************************************
   // bank and buffer select
   // ************************************************************
   // unused bits never stored; codes 2 and 3 are kept as written
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bank_r <= RST_BANK;
      end else if (wsel_r[SLOT_BANK]) begin
         bank_r <= wbyte & MASK_BANK;
      end
   end

   // host fifo routing holds only while in standby
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fifo_read_select <= 1'b0;
      end else begin
         fifo_read_select <= standby && bank_r[BIT_BUF_DIR];
      end
   end

   // ************************************************************
   // supply monitor
   // ************************************************************
   // reserved bits are stored as written; software keeps them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         batt_ctrl_r <= RST_BATT_CTRL;
      end else if (wsel_r[SLOT_BATT_CTRL]) begin
         batt_ctrl_r <= wbyte;
      end
   end

   // bit 7 is the live comparator, so it is never stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         batt_stat_r <= RST_BATT_STAT & MASK_BATT_STAT;
      end else if (wsel_r[SLOT_BATT_STAT]) begin
         batt_stat_r <= wbyte & MASK_BATT_STAT;
      end
   end

   // alert only while monitoring, routed and below the trip level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_supply_pin <= 1'b0;
      end else begin
         low_supply_pin <= batt_stat_r[BIT_ALERT_ROUTE]
                           && batt_ctrl_r[BIT_MON_EN] && !supply_above;
      end
   end

   assign supply_monitor_enable = batt_ctrl_r[BIT_MON_EN];
   assign supply_threshold      = batt_ctrl_r[THR_MSB:0];

   // ************************************************************
   // settings out to the datapath
   // ************************************************************
   assign line_coding_en  = coding_r[BIT_LINE_CODE];
   assign pkt_len         = coding_r[LEN_MSB:0];
   assign frame_variable  = framing_r[BIT_FRAME_MODE];
   // code 0 means one byte, so the count is the code plus one
   assign preamble_bytes  = {1'b0, framing_r[PRE_MSB:PRE_LSB]} + 3'd1;
   assign whitening_en    = framing_r[BIT_WHITEN];
   assign checksum_en     = framing_r[BIT_CHECKSUM];
   assign addr_match_mode = pbcb_match_type'(framing_r[MATCH_MSB:MATCH_LSB]);
   assign station_id      = station_r;

   // ************************************************************
   // receive checker
   // ************************************************************
   assign rx_bus.station_id  = station_r;
   assign rx_bus.match_mode  = addr_match_mode;
   assign rx_bus.checksum_en = checksum_en;
   assign rx_bus.auto_flush  = bank_r[BIT_AUTO_FLUSH];
   assign rx_bus.rx_active   = rx_active;
   assign rx_bus.crc_done    = crc_done;
   assign rx_bus.crc_ok      = crc_ok;
   assign rx_bus.addr_valid  = rx_addr_valid;
   assign rx_bus.addr_byte   = rx_addr_byte;

   pbcb_rx_check u_rx_check (
      .hclk    (hclk),
      .hresetn (hresetn),
      .rx      (rx_bus.check)
   );

   assign crc_status     = rx_bus.crc_status;
   assign fifo_flush     = rx_bus.flush;
   assign rx_addr_done   = rx_bus.addr_accept_valid;
   assign rx_addr_accept = rx_bus.addr_accept;

endmodule // pbcb_top
`default_nettype wire

/* File: dv/pbcb_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module pbcb_monitor import pbcb_pkg::*; (
   input wire logic           hclk, hresetn, hsel, hwrite, hready, // bus control
   input wire logic [31:0]    haddr, hwdata, hrdata,               // bus data
   input wire logic [1:0]     htrans,                              // transfer type
   input wire logic [2:0]     preamble_bytes,                      // lead-in bytes
   input wire logic [7:0]     station_id, rx_addr_byte,            // filter data
   input wire pbcb_pkg::pbcb_match_type addr_match_mode,           // filter mode
   input wire logic           checksum_en, standby, fifo_read_select, rx_active, // rx
   input wire logic           crc_done, crc_ok, fifo_flush, rx_addr_valid,  // rx events
   input wire logic           rx_addr_done, rx_addr_accept, supply_monitor_enable, // out
   input wire logic           supply_above, low_supply_pin         // supply
);
   // ********************
   // bus shadow and checks
   // ********************
   logic       tk, pg0, ph_wr, ph_rd, route_q, acc_w;
   logic [5:0] ph_idx;
   logic [7:0] bank_q;

   // mapped address phase only
   assign tk  = hsel && hready && htrans == HTRANS_NONSEQ && haddr[31:8] == 24'h000000
                && haddr[1:0] == 2'h0;
   assign pg0 = bank_q[1:0] == PAGE_0;
   // verdict owed for this byte
   assign acc_w = addr_match_mode == MATCH_NONE || rx_addr_byte == station_id
                  || (addr_match_mode[1] && rx_addr_byte == BCAST_ZERO)
                  || (addr_match_mode == MATCH_BOTH && rx_addr_byte == BCAST_ONES);

   // data phase tracking
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr  <= 1'b0;
         ph_rd  <= 1'b0;
         ph_idx <= 6'h00;
      end else begin
         ph_wr  <= tk && hwrite;
         ph_rd  <= tk && !hwrite;
         ph_idx <= haddr[7:2];
      end
   end

   // shadow of page, flush and routing bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bank_q  <= RST_BANK;
         route_q <= RST_BATT_STAT[BIT_ALERT_ROUTE];
      end else if (ph_wr && ph_idx == IDX_BANK) begin
         bank_q <= hwdata[7:0] & MASK_BANK;
      end else if (ph_wr && ph_idx == IDX_BATT_STAT && bank_q[1:0] == PAGE_1) begin
         route_q <= hwdata[BIT_ALERT_ROUTE];
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_station_write: assert property (
      ph_wr && ph_idx == IDX_STATION && pg0 |=> station_id == $past(hwdata[7:0]))
      else $error("station id not taken from write");
   a_preamble_code: assert property (
      ph_wr && ph_idx == IDX_FRAMING && pg0 |=> preamble_bytes == {1'b0, $past(hwdata[6:5])} + 3'h1)
      else $error("lead-in length wrong");
   a_flush_cause: assert property (
      fifo_flush == $past(crc_done && !crc_ok && rx_active && checksum_en && !bank_q[7]))
      else $error("flush pulse wrong");
   a_dir_standby: assert property (
      fifo_read_select == $past(standby && bank_q[6]))
      else $error("buffer direction wrong");
   a_filter_verdict: assert property (
      rx_addr_valid |=> rx_addr_done && rx_addr_accept == $past(acc_w))
      else $error("address verdict wrong");
   a_verdict_cause: assert property (
      rx_addr_done |-> $past(rx_addr_valid))
      else $error("verdict without address");
   a_low_pin: assert property (
      low_supply_pin == $past(route_q && supply_monitor_enable && !supply_above))
      else $error("alert pin wrong");
   a_hidden_batt: assert property (
      ph_rd && ph_idx == IDX_BATT_CTRL && bank_q[1:0] != PAGE_1 |-> hrdata == 32'h00000000)
      else $error("battery register seen off page");
   a_bank_readback: assert property (
      ph_rd && ph_idx == IDX_BANK |-> hrdata == {24'h000000, bank_q})
      else $error("bank register readback wrong");

   c_flush: cover property (fifo_flush);
   c_accept: cover property (rx_addr_done && rx_addr_accept);
   c_alert: cover property (low_supply_pin);
endmodule // pbcb_monitor

bind pbcb_top pbcb_monitor pbcb_monitor_i (.*);
`default_nettype wire

/* File: dv/pbcb_host.sv */
`timescale 1ns/1ps
`default_nettype none
module pbcb_host import pbcb_pkg::*; (
   input  wire logic        hclk,   // bus clock
   input  wire logic        hready, // slave ready
   input  wire logic [31:0] hrdata, // read data
   output logic [31:0]      haddr,  // byte address
   output logic [1:0]       htrans, // transfer type
   output logic             hwrite, // 1 = write
   output logic [31:0]      hwdata  // write data
);
   // ********************
   // host software model
   // ********************
   // idle bus at time zero
   initial begin
      haddr  = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'hA5A5A5A5;
   end

   // one word; only hready ends each phase
   task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge hclk);
      haddr  <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata[7:0];
      // released data shows the inverse
      hwdata <= ~hwdata;
   endtask
endmodule // pbcb_host
`default_nettype wire

/* File: dv/test_packet_and_battery_config_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module test_packet_and_battery_config_bank;
   import pbcb_pkg::*;
   // ********************
   // bench
   // ********************
   logic           hclk, hresetn, hresp, hwrite, hreadyout, standby, rx_active, crc_done, crc_ok;
   logic           rx_addr_valid, supply_above, line_coding_en, frame_variable;
   logic           whitening_en, checksum_en, fifo_read_select, fifo_flush, rx_addr_done;
   logic           rx_addr_accept, supply_monitor_enable, low_supply_pin;
   logic [1:0]     htrans;
   logic [2:0]     preamble_bytes, supply_threshold;
   logic [6:0]     pkt_len;
   logic [7:0]     station_id, rx_addr_byte, st, cod, b;
   logic [15:0]    rnd;
   logic [31:0]    haddr, hwdata, hrdata;
   pbcb_match_type addr_match_mode;
   int             miscompares = 0, tests_run = 0, cycles = 0;

   pbcb_top pbcb_top_i (.*, .hsel(1'b1), .hsize(3'h2), .hready(hreadyout));
   pbcb_host pbcb_host_i (
      .hclk, .hready(hreadyout), .hrdata, .haddr, .htrans, .hwrite, .hwdata
   );

   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // watchdog; run needs under 1000 cycles
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares = miscompares + 1;
         stop_test();
      end
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic accept(input logic [1:0] m, input logic [7:0] s, input logic [7:0] v);
      return m == 2'h0 || v == s || (m[1] && v == 8'h00) || (m == 2'h3 && v == 8'hFF);
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      tests_run = tests_run + 1;
      if (got !== want) begin
         miscompares = miscompares + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      logic [7:0] q;
      pbcb_host_i.xfer(1'b1, {24'h000000, i, 2'h0}, d, q);
      #1;
   endtask
   task automatic rd_chk(input logic [5:0] i, input logic [7:0] want);
      logic [7:0] q;
      pbcb_host_i.xfer(1'b0, {24'h000000, i, 2'h0}, 8'h00, q);
      #1;
      chk(q, want);
   endtask
   // one address byte, verdict due on the next cycle
   task automatic probe(input logic [7:0] v, input logic want);
      rx_addr_valid <= 1'b1;
      rx_addr_byte  <= v;
      @(posedge hclk);
      rx_addr_valid <= 1'b0;
      rx_addr_byte  <= ~v;
      #1;
      chk({6'h00, rx_addr_done, rx_addr_accept}, {7'h01, want});
   endtask
   task automatic crc(input logic ok, input logic fl);
      crc_done <= 1'b1;
      crc_ok   <= ok;
      @(posedge hclk);
      crc_done <= 1'b0;
      crc_ok   <= ~ok;
      #1;
      chk(8'(fifo_flush), 8'(fl));
   endtask
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      hresetn       = 1'b0;
      standby       = 1'b0;
      rx_active     = 1'b0;
      crc_done      = 1'b0;
      crc_ok        = 1'b0;
      rx_addr_valid = 1'b0;
      rx_addr_byte  = 8'h00;
      supply_above  = 1'b1;
      rnd           = 16'h074D;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(IDX_CODING, RST_CODING);
      rd_chk(IDX_STATION, RST_STATION);
      rd_chk(IDX_BANK, RST_BANK);
      // page 1 detector; reserved bits kept
      wr(IDX_BANK, 8'h01);
      rd_chk(IDX_BATT_STAT, {1'b1, RST_BATT_STAT[6:0]});
      rd_chk(IDX_BATT_CTRL, RST_BATT_CTRL);
      rnd = lfsr(rnd);
      wr(IDX_BATT_CTRL, {4'hB, rnd[3:0]});
      chk({supply_monitor_enable, supply_threshold}, rnd[3:0]);
      supply_above <= 1'b0;
      wr(IDX_BATT_STAT, 8'hD6);
      rd_chk(IDX_BATT_STAT, 8'h56);
      chk(8'(low_supply_pin), 8'(rnd[3]));
      wr(IDX_BANK, 8'h00);
      rd_chk(IDX_BATT_CTRL, 8'h00);
      // random page 0 settings seen at the pins
      for (int i = 0; i < 12; i++) begin
         rnd = lfsr(rnd);
         cod = rnd[7:0];
         wr(IDX_CODING, cod);
         chk({line_coding_en, pkt_len}, cod);
         wr(IDX_FRAMING, rnd[15:8]);
         chk(8'(preamble_bytes), 8'(rnd[14:13]) + 8'h01);
         chk({frame_variable, whitening_en, checksum_en, addr_match_mode}, {rnd[15], rnd[12:9]});
         rd_chk(IDX_FRAMING, {rnd[15:9], 1'b0});
      end
      // each match mode, four bytes
      st = 8'h3C ^ {4'h0, rnd[3:0]};
      wr(IDX_STATION, st);
      chk(station_id, st);
      for (int m = 0; m < 4; m++) begin
         wr(IDX_FRAMING, {5'h00, 2'(m), 1'b0});
         for (int j = 0; j < 4; j++) begin
            b = (j == 0) ? st : (j == 1) ? BCAST_ZERO : (j == 2) ? BCAST_ONES : st ^ 8'h80;
            probe(b, accept(2'(m), st, b));
         end
      end
      // unused pages hide all but the bank register
      for (int p = 2; p < 4; p++) begin
         rnd = lfsr(rnd);
         standby <= (p == 2);
         wr(IDX_BANK, {rnd[7], 1'b1, rnd[5:2], 2'(p)});
         rd_chk(IDX_BANK, {rnd[7], 1'b1, 4'h0, 2'(p)});
         wr(IDX_CODING, ~cod);
         rd_chk(IDX_CODING, 8'h00);
         chk(8'(fifo_read_select), 8'(p == 2));
      end
      wr(IDX_BANK, 8'h00);
      rd_chk(IDX_CODING, cod);
      pbcb_host_i.xfer(1'b1, 32'h0000017C, 8'h01, b);
      chk(8'(hresp), 8'(HRESP_OKAY));
      rd_chk(IDX_BANK, 8'h00);
      // checksum result, write-one clear, flush on failure
      rx_active <= 1'b1;
      wr(IDX_FRAMING, 8'h08);
      crc(1'b1, 1'b0);
      rd_chk(IDX_FRAMING, 8'h09);
      wr(IDX_FRAMING, 8'h09);
      rd_chk(IDX_FRAMING, 8'h08);
      crc(1'b1, 1'b0);
      crc(1'b0, 1'b1);
      rd_chk(IDX_FRAMING, 8'h08);
      wr(IDX_BANK, 8'h80);
      crc(1'b0, 1'b0);
      wr(IDX_FRAMING, 8'h00);
      wr(IDX_BANK, 8'h00);
      crc(1'b0, 1'b0);
      stop_test();
   end
endmodule // test_packet_and_battery_config_bank
`default_nettype wire
